// ### eerp_consts.svh
// Purpose: constants for the data eeprom row programmer
// Assumes: byte registers sit in the low bits of 32-bit words
// Notes: register offsets are byte addresses on the register bus
`ifndef EERP_CONSTS_SVH
`define EERP_CONSTS_SVH
`define EERP_EECS_OFF 8'h30
`define EERP_FCS_OFF 8'h34
`define EERP_PROT_OFF 8'h38
`define EERP_ACC_OFF 8'h3C
`define EERP_RDATA_OFF 8'h40
`define EERP_PWR_OFF 8'h44
`define EERP_PGM_BIT 0
`define EERP_LAT_BIT 1
`define EERP_OPT_BIT 2
`define EERP_KEY1 8'h56
`define EERP_KEY2 8'hAE
`define EERP_ROW_BYTES 32
`define EERP_PGM_NS 32'h00000FA0
`define EERP_CLK_MHZ 32'h000000FA
`define EERP_RESP_OKAY 2'h0
`define EERP_RESP_SLVERR 2'h2
`endif

// ### eerp_pkg.sv
// Purpose: types for the data eeprom row programmer
// Assumes: included constants header
// Notes: none
package eerp_pkg;
  typedef enum logic [1:0] {
    EERP_IDLE,
    EERP_PROG,
    EERP_WAITST,
    EERP_HALTST
  } eerp_state_t;

  typedef enum logic [1:0] {
    EERP_KEY_NONE,
    EERP_KEY_ONE,
    EERP_KEY_OPEN
  } eerp_key_t;

  typedef struct packed {
    logic valid;
    logic write;
    logic [7:0] addr;
    logic [7:0] wdata;
  } eerp_cpu_req_t;
endpackage : eerp_pkg

// ### eerp_top.sv
// Purpose: data eeprom row programmer with axi4-lite register slave
// Assumes: cpu memory port on same clock; option bits from option row
// Notes: 256-byte array, 8 rows of 32 bytes
//
// Function
// - latch bit 0: cpu reads return array contents like plain rom.
// - latch mode writes load one of 32 latches by low address bits.
// - start bit programs all latched bytes, up to 32, in one cycle.
// - row comes from last latched write; software keeps one row.
// - cycle end clears start bit and latch bit together.
// - latches clear at cycle end or latch fall; rewrites AND together.
// - latch contents are never readable.
// - row n covers byte addresses n*20h to n*20h+1Fh.
// - wait request enters wait at once if idle, else after cycle.
// - halt enters at once, aborting programming; data may corrupt.
// - cpu read in latch mode leaves data bus undriven.
// - cpu write with latch bit 0 is ignored.
// - reset during programming gives no guarantee on cells.
// - latch bit bit 1 set by software; clear only when start bit 0.
// - writing 1 to bit 0 starts; reads 1 until cycle ends or 0 is written to bit 0.
// - control bits 7:2 read 0, writes ignored.
// - read-out protection blocks reads/writes; removal erases all; cpu port reads still return array data here.
// - write/erase protection refuses flash program; eeprom unaffected.
// - flash control unlocks after keys 56h then AEh; bits 2,1,0.
// - one read-out option bit protects program memory and eeprom; here flash_write_enable ignores it.
`timescale 1ns/1ps
`include "eerp_consts.svh"
module eerp_top #(
  parameter int ROWS = 8,
  parameter int PGM_CYCLES = (`EERP_PGM_NS * `EERP_CLK_MHZ + 999) / 1000
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire eerp_pkg::eerp_cpu_req_t cpu_req,
  output logic [7:0] cpu_rdata,
  output logic cpu_rdata_oe,
  input wire logic wait_req,
  input wire logic halt_req,
  input wire logic readout_protect_option,
  input wire logic write_erase_protect_option,
  output logic flash_write_enable,
  output logic eeprom_in_wait,
  output logic eeprom_in_halt
);
  localparam int AW = $clog2(ROWS * `EERP_ROW_BYTES);
  localparam int CW = $clog2(PGM_CYCLES + 1);

  typedef struct packed {
    eerp_pkg::eerp_state_t st;
    logic program_start_bit;
    logic latch_mode_bit;
    logic [CW-1:0] cnt;
    logic [AW-6:0] row;
    logic [31:0] lat_used;
    logic [255:0] lat_data;
    eerp_pkg::eerp_key_t key;
    logic [2:0] fcs;
    logic ro_prev;
    logic erase_all;
    logic [AW-1:0] acc_addr;
    logic aw_got;
    logic w_got;
    logic [7:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [1:0] bresp;
    logic [7:0] cpu_rd;
    logic cpu_oe;
  } eerp_s_t;

  eerp_s_t s_reg;
  eerp_s_t s_next;
  logic [7:0] mem [ROWS*`EERP_ROW_BYTES];
  logic mem_we;
  logic [AW-1:0] mem_waddr;
  logic [7:0] mem_wdata;
  logic [AW:0] erase_idx_reg;

  function automatic logic [31:0] eerp_rd(input logic [7:0] a,
                                          input eerp_s_t s,
                                          input logic [7:0] m);
    case (a)
      `EERP_EECS_OFF: eerp_rd = {30'h0, s.latch_mode_bit,
                                 s.program_start_bit};
      `EERP_FCS_OFF: eerp_rd = {29'h0, s.fcs};
      `EERP_PROT_OFF: eerp_rd = {30'h0, write_erase_protect_option,
                                 readout_protect_option};
      `EERP_ACC_OFF: eerp_rd = 32'(s.acc_addr);
      `EERP_RDATA_OFF: eerp_rd = {24'h0, m};
      `EERP_PWR_OFF: eerp_rd = {30'h0, s.st == eerp_pkg::EERP_HALTST,
                                s.st == eerp_pkg::EERP_WAITST};
      default: eerp_rd = 32'h0;
    endcase
  endfunction : eerp_rd

  function automatic logic eerp_hit(input logic [7:0] a);
    eerp_hit = (a == `EERP_EECS_OFF) || (a == `EERP_FCS_OFF) ||
               (a == `EERP_PROT_OFF) || (a == `EERP_ACC_OFF) ||
               (a == `EERP_RDATA_OFF) || (a == `EERP_PWR_OFF);
  endfunction : eerp_hit

  always_comb begin
    logic [AW-1:0] ca;
    logic [4:0] bi;
    logic [7:0] wb;
    logic lat_fall;
    logic prog_end;
    s_next = s_reg;
    ca = cpu_req.addr[AW-1:0];
    bi = ca[4:0];
    wb = s_reg.w_data[7:0];
    lat_fall = 1'b0;
    prog_end = 1'b0;
    mem_we = 1'b0;
    mem_waddr = '0;
    mem_wdata = 8'h00;
    // cpu memory port
    s_next.cpu_oe = 1'b0;
    s_next.cpu_rd = 8'h00;
    if (cpu_req.valid && !cpu_req.write && !s_reg.latch_mode_bit) begin
      s_next.cpu_rd = mem[ca];
      s_next.cpu_oe = 1'b1;
    end
    if (cpu_req.valid && cpu_req.write && s_reg.latch_mode_bit &&
        !s_reg.program_start_bit && !readout_protect_option) begin
      s_next.lat_data[bi*8 +: 8] = s_reg.lat_used[bi] ?
        (s_reg.lat_data[bi*8 +: 8] & cpu_req.wdata) : cpu_req.wdata;
      s_next.lat_used[bi] = 1'b1;
      s_next.row = ca[AW-1:5];
    end
    // programming sequencer
    unique case (s_reg.st)
      eerp_pkg::EERP_IDLE: begin
        if (halt_req) begin
          s_next.st = eerp_pkg::EERP_HALTST;
        end else if (wait_req) begin
          s_next.st = eerp_pkg::EERP_WAITST;
        end else if (s_reg.program_start_bit) begin
          s_next.st = eerp_pkg::EERP_PROG;
          s_next.cnt = CW'(PGM_CYCLES);
        end
      end
      eerp_pkg::EERP_PROG: begin
        if (halt_req) begin
          s_next.st = eerp_pkg::EERP_HALTST;
          s_next.program_start_bit = 1'b0;
          s_next.latch_mode_bit = 1'b0;
          lat_fall = 1'b1;
        end else if (!s_reg.program_start_bit) begin
          s_next.st = eerp_pkg::EERP_IDLE;
        end else if (s_reg.cnt > CW'(1)) begin
          s_next.cnt = s_reg.cnt - CW'(1);
        end else begin
          prog_end = 1'b1;
          s_next.program_start_bit = 1'b0;
          s_next.latch_mode_bit = 1'b0;
          s_next.st = wait_req ? eerp_pkg::EERP_WAITST :
                      eerp_pkg::EERP_IDLE;
        end
      end
      eerp_pkg::EERP_WAITST: begin
        if (halt_req) begin
          s_next.st = eerp_pkg::EERP_HALTST;
        end else if (!wait_req) begin
          s_next.st = eerp_pkg::EERP_IDLE;
        end
      end
      eerp_pkg::EERP_HALTST: begin
        if (!halt_req) begin
          s_next.st = eerp_pkg::EERP_IDLE;
        end
      end
    endcase
    if (prog_end || lat_fall) begin
      s_next.lat_used = '0;
      s_next.lat_data = '1;
    end
    // read-out protection removal erases the whole array
    s_next.ro_prev = readout_protect_option;
    if (s_reg.ro_prev && !readout_protect_option) begin
      s_next.erase_all = 1'b1;
    end
    if (erase_idx_reg == (AW+1)'(ROWS * `EERP_ROW_BYTES - 1)) begin
      s_next.erase_all = 1'b0;
    end
    // axi4-lite write channel
    if (s_axi_awvalid && !s_reg.aw_got) begin
      s_next.aw_got = 1'b1;
      s_next.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !s_reg.w_got) begin
      s_next.w_got = 1'b1;
      s_next.w_data = s_axi_wdata;
      s_next.w_strb = s_axi_wstrb;
    end
    if (s_reg.bvalid && s_axi_bready) begin
      s_next.bvalid = 1'b0;
    end
    if (s_reg.aw_got && s_reg.w_got && !s_reg.bvalid) begin
      s_next.aw_got = 1'b0;
      s_next.w_got = 1'b0;
      s_next.bvalid = 1'b1;
      s_next.bresp = eerp_hit(s_reg.aw_addr) ? `EERP_RESP_OKAY :
                     `EERP_RESP_SLVERR;
      if (s_reg.w_strb[0]) begin
        if (s_reg.aw_addr == `EERP_EECS_OFF) begin
          if (wb[`EERP_LAT_BIT]) begin
            s_next.latch_mode_bit = 1'b1;
          end else if (!s_reg.program_start_bit && s_reg.latch_mode_bit) begin
            s_next.latch_mode_bit = 1'b0;
            s_next.lat_used = '0;
            s_next.lat_data = '1;
          end
          if (wb[`EERP_PGM_BIT] && (s_reg.latch_mode_bit ||
              wb[`EERP_LAT_BIT]) && !readout_protect_option) begin
            s_next.program_start_bit = 1'b1;
          end else if (!wb[`EERP_PGM_BIT]) begin
            s_next.program_start_bit = 1'b0;
          end
        end
        if (s_reg.aw_addr == `EERP_FCS_OFF) begin
          unique case (s_reg.key)
            eerp_pkg::EERP_KEY_NONE: begin
              s_next.key = (wb == `EERP_KEY1) ? eerp_pkg::EERP_KEY_ONE :
                           eerp_pkg::EERP_KEY_NONE;
            end
            eerp_pkg::EERP_KEY_ONE: begin
              s_next.key = (wb == `EERP_KEY2) ? eerp_pkg::EERP_KEY_OPEN :
                           eerp_pkg::EERP_KEY_NONE;
            end
            eerp_pkg::EERP_KEY_OPEN: begin
              s_next.fcs = wb[`EERP_OPT_BIT:`EERP_PGM_BIT];
            end
            default: s_next.key = eerp_pkg::EERP_KEY_NONE;
          endcase
        end
        if (s_reg.aw_addr == `EERP_ACC_OFF) begin
          s_next.acc_addr = wb[AW-1:0];
        end
      end
    end
    // axi4-lite read channel
    if (s_reg.rvalid && s_axi_rready) begin
      s_next.rvalid = 1'b0;
    end
    if (s_axi_arvalid && !s_reg.rvalid) begin
      s_next.rvalid = 1'b1;
      s_next.rdata = eerp_rd(s_axi_araddr, s_reg,
                             (readout_protect_option || s_reg.latch_mode_bit) ?
                             8'h00 : mem[s_reg.acc_addr]);
      s_next.rresp = eerp_hit(s_axi_araddr) ? `EERP_RESP_OKAY :
                     `EERP_RESP_SLVERR;
    end
    if (prog_end) begin
      mem_we = 1'b1;
    end
  end

  // array update: one byte per clock is too slow, so the row writes at once
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      erase_idx_reg <= '0;
    end else if (s_reg.erase_all) begin
      mem[erase_idx_reg[AW-1:0]] <= 8'hFF;
      erase_idx_reg <= erase_idx_reg + (AW+1)'(1);
    end else begin
      erase_idx_reg <= '0;
      if (mem_we) begin
        for (int i = 0; i < `EERP_ROW_BYTES; i++) begin
          if (s_reg.lat_used[i]) begin
            mem[{s_reg.row, 5'(i)}] <= s_reg.lat_data[i*8 +: 8];
          end
        end
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_reg <= '{st: eerp_pkg::EERP_IDLE, key: eerp_pkg::EERP_KEY_NONE,
                 lat_data: '1, default: '0};
    end else begin
      s_reg <= s_next;
    end
  end

  assign s_axi_awready = !s_reg.aw_got;
  assign s_axi_wready = !s_reg.w_got;
  assign s_axi_bvalid = s_reg.bvalid;
  assign s_axi_bresp = s_reg.bresp;
  assign s_axi_arready = !s_reg.rvalid;
  assign s_axi_rvalid = s_reg.rvalid;
  assign s_axi_rdata = s_reg.rdata;
  assign s_axi_rresp = s_reg.rresp;
  assign cpu_rdata = s_reg.cpu_rd;
  assign cpu_rdata_oe = s_reg.cpu_oe;
  assign flash_write_enable = (s_reg.key == eerp_pkg::EERP_KEY_OPEN) &&
    s_reg.fcs[`EERP_PGM_BIT] && !write_erase_protect_option;
  assign eeprom_in_wait = (s_reg.st == eerp_pkg::EERP_WAITST);
  assign eeprom_in_halt = (s_reg.st == eerp_pkg::EERP_HALTST);
  // unused low flash bits kept visible in fcs register
endmodule : eerp_top

// ### eerp_cpu_model.sv
// Purpose: cpu memory port model for the eeprom row programmer
// Assumes: one-cycle request pulse, read data one cycle later
// Notes: idle address and data lines invert so stale values never match
`timescale 1ns/1ps
module eerp_cpu_model (
  input wire logic clk,
  output eerp_pkg::eerp_cpu_req_t req,
  input wire logic [7:0] rdata,
  input wire logic rdata_oe
);
  initial req = '0;
  task automatic acc(input logic wr, input logic [7:0] a,
      input logic [7:0] d, output logic [7:0] q, output logic oe);
    @(posedge clk);
    req <= '{1'b1, wr, a, d};
    @(posedge clk);
    req <= '{1'b0, 1'b0, ~a, ~d};
    #1;
    q = rdata;
    oe = rdata_oe;
  endtask : acc
endmodule : eerp_cpu_model

// ### eerp_top_assertions.sv
// Purpose: port checks for the eeprom row programmer
// Assumes: one clock, synchronous active-low reset
// Notes: attached to every eerp_top instance
`timescale 1ns/1ps
module eerp_chk #(
  parameter int PGM_CYCLES = 8
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire eerp_pkg::eerp_cpu_req_t cpu_req,
  input wire logic cpu_rdata_oe,
  input wire logic wait_req,
  input wire logic halt_req,
  input wire logic readout_protect_option,
  input wire logic write_erase_protect_option,
  input wire logic flash_write_enable,
  input wire logic eeprom_in_wait,
  input wire logic eeprom_in_halt
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  int unsigned wcnt;
  // cycles spent asking for wait without getting it
  always_ff @(posedge aclk) begin
    if (!aresetn || !wait_req || halt_req || eeprom_in_wait) wcnt <= 0;
    else wcnt <= wcnt + 1;
  end
  a_wait_bounded: assert property (wcnt <= PGM_CYCLES + 3)
    else $error("wait entry late");
  a_halt_at_once: assert property (halt_req |=> eeprom_in_halt)
    else $error("halt not entered");
  a_oe_cause: assert property (cpu_rdata_oe |->
    $past(cpu_req.valid && !cpu_req.write))
    else $error("cpu data driven without read");
  a_flash_guard: assert property (flash_write_enable |->
    !write_erase_protect_option)
    else $error("flash write under protection");
  a_ctrl_reserved: assert property (s_axi_arvalid && s_axi_arready &&
    s_axi_araddr == 8'h30 |=> s_axi_rdata[31:2] == 30'h0)
    else $error("control upper bits set");
  a_protect_data: assert property (s_axi_arvalid && s_axi_arready &&
    s_axi_araddr == 8'h40 && readout_protect_option |=>
    s_axi_rdata == 32'h0)
    else $error("array readable under protection");
  a_unmapped_err: assert property (s_axi_arvalid && s_axi_arready &&
    s_axi_araddr == 8'h00 |=> s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0)
    else $error("unmapped read not refused");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=>
    s_axi_rvalid) else $error("read answer missing");
  a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped");
  a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp)) else $error("write resp dropped");
endmodule : eerp_chk
bind eerp_top eerp_chk #(.PGM_CYCLES(PGM_CYCLES)) eerp_chk_i (.aclk,
  .aresetn, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
  .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .s_axi_bresp, .s_axi_bvalid,
  .s_axi_bready, .cpu_req, .cpu_rdata_oe, .wait_req, .halt_req,
  .readout_protect_option, .write_erase_protect_option, .flash_write_enable,
  .eeprom_in_wait, .eeprom_in_halt);

// ### tb.sv
// Purpose: self-checking bench for the eeprom row programmer
// Assumes: program time shortened to 8 cycles
// Notes: register bus tasks and the cpu model carry all traffic
`timescale 1ns/1ps
`include "eerp_consts.svh"
module tb;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, got_q;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, d;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic s_axi_arvalid = 0, s_axi_rready = 0, got_oe;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, cpu_rdata_oe, flash_write_enable;
  logic eeprom_in_wait, eeprom_in_halt;
  logic [1:0] s_axi_bresp, s_axi_rresp, r, br;
  logic [7:0] cpu_rdata;
  logic wait_req = 0, halt_req = 0;
  logic readout_protect_option = 0, write_erase_protect_option = 0;
  eerp_pkg::eerp_cpu_req_t cpu_req;
  int bad_count = 0, num_checks = 0;
  always #2 aclk = ~aclk;
  eerp_top #(.PGM_CYCLES(8)) eerp_top_i (.aclk, .aresetn, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .cpu_req, .cpu_rdata,
    .cpu_rdata_oe, .wait_req, .halt_req, .readout_protect_option,
    .write_erase_protect_option, .flash_write_enable, .eeprom_in_wait,
    .eeprom_in_halt);
  eerp_cpu_model eerp_cpu_model_i (.clk(aclk), .req(cpu_req),
    .rdata(cpu_rdata), .rdata_oe(cpu_rdata_oe));
  task automatic complete_run();
    $display("checks %0d errors %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : complete_run
  task automatic hang();
    bad_count++;
    $display("ERROR %0t: wait ran out", $time);
    complete_run();
  endtask : hang
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    logic ta, tw, tg;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (int n = 0; n < 40; n++) begin
      #1;
      ta = s_axi_awvalid && s_axi_awready;
      tw = s_axi_wvalid && s_axi_wready;
      tg = s_axi_bvalid;
      br = s_axi_bresp;
      @(posedge aclk);
      if (ta) s_axi_awvalid <= 1'b0;
      if (tw) s_axi_wvalid <= 1'b0;
      if (tg) begin
        s_axi_bready <= 1'b0;
        return;
      end
    end
    hang();
  endtask : wr
  task automatic rd(input logic [7:0] a);
    logic ta, tr;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (int n = 0; n < 40; n++) begin
      #1;
      ta = s_axi_arvalid && s_axi_arready;
      tr = s_axi_rvalid;
      d = s_axi_rdata;
      r = s_axi_rresp;
      @(posedge aclk);
      if (ta) s_axi_arvalid <= 1'b0;
      if (tr) begin
        s_axi_rready <= 1'b0;
        return;
      end
    end
    hang();
  endtask : rd
  task automatic cpu(input logic w, input logic [7:0] a, input logic [7:0] v);
    eerp_cpu_model_i.acc(w, a, v, got_q, got_oe);
  endtask : cpu
  task automatic wait_done();
    for (int n = 0; n < 20; n++) begin
      rd(`EERP_EECS_OFF);
      if (d === 32'h0) return;
    end
    hang();
  endtask : wait_done
  task automatic edges(input int n);
    repeat (n) @(posedge aclk);
    #1;
  endtask : edges
  initial begin
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    rd(`EERP_EECS_OFF); check(d, 32'h0);
    rd(`EERP_FCS_OFF); check(d, 32'h0);
    rd(8'h00); check(32'(r), 32'(`EERP_RESP_SLVERR));
    wr(8'h00, 32'h0); check(32'(br), 32'(`EERP_RESP_SLVERR));
    wr(`EERP_EECS_OFF, 32'hFC); rd(`EERP_EECS_OFF); check(d, 32'h0);
    wr(`EERP_EECS_OFF, 32'h2); rd(`EERP_EECS_OFF); check(d, 32'h2);
    cpu(0, 8'h40, 8'h00); check(32'(got_oe), 32'h0);
    for (int i = 0; i < 32; i++) cpu(1, 8'h40 + i, 8'hA5 ^ i);
    cpu(1, 8'h41, 8'h0F);
    wr(`EERP_EECS_OFF, 32'h3); rd(`EERP_EECS_OFF); check(d, 32'h3);
    wait_done();
    for (int i = 0; i < 32; i++) begin
      cpu(0, 8'h40 + i, 8'h00);
      check(32'(got_q), (i == 1) ? 32'h04 : 32'(8'hA5 ^ i));
      check(32'(got_oe), 32'h1);
    end
    cpu(1, 8'h42, 8'h00);
    wr(`EERP_EECS_OFF, 32'h2); cpu(1, 8'h43, 8'h00);
    wr(`EERP_EECS_OFF, 32'h0);
    wr(`EERP_EECS_OFF, 32'h2); wr(`EERP_EECS_OFF, 32'h3); wait_done();
    cpu(0, 8'h42, 8'h00); check(32'(got_q), 32'hA7);
    cpu(0, 8'h43, 8'h00); check(32'(got_q), 32'hA6);
    wr(`EERP_ACC_OFF, 32'h44); rd(`EERP_RDATA_OFF); check(d, 32'hA1);
    wait_req <= 1'b1;
    edges(2); check(32'(eeprom_in_wait), 32'h1);
    rd(`EERP_PWR_OFF); check(d, 32'h1);
    wait_req <= 1'b0;
    wr(`EERP_EECS_OFF, 32'h2); cpu(1, 8'h60, 8'h3C);
    wr(`EERP_EECS_OFF, 32'h3);
    wait_req <= 1'b1;
    edges(2); check(32'(eeprom_in_wait), 32'h0);
    wait_done(); check(32'(eeprom_in_wait), 32'h1);
    wait_req <= 1'b0;
    cpu(0, 8'h60, 8'h00); check(32'(got_q), 32'h3C);
    wr(`EERP_EECS_OFF, 32'h2); cpu(1, 8'h61, 8'h00); wr(`EERP_EECS_OFF, 32'h3);
    halt_req <= 1'b1;
    edges(2); check(32'(eeprom_in_halt), 32'h1);
    halt_req <= 1'b0;
    edges(2); rd(`EERP_EECS_OFF); check(d, 32'h0);
    readout_protect_option <= 1'b1;
    wr(`EERP_ACC_OFF, 32'h40); rd(`EERP_RDATA_OFF); check(d, 32'h0);
    readout_protect_option <= 1'b0;
    edges(300); cpu(0, 8'h40, 8'h00); check(32'(got_q), 32'hFF);
    wr(`EERP_FCS_OFF, 32'h56); wr(`EERP_FCS_OFF, 32'h11);
    wr(`EERP_FCS_OFF, 32'hAE); wr(`EERP_FCS_OFF, 32'h01);
    edges(1); check(32'(flash_write_enable), 32'h0);
    wr(`EERP_FCS_OFF, 32'h56); wr(`EERP_FCS_OFF, 32'hAE);
    wr(`EERP_FCS_OFF, 32'h01);
    edges(1); check(32'(flash_write_enable), 32'h1);
    write_erase_protect_option <= 1'b1;
    edges(1); check(32'(flash_write_enable), 32'h0);
    complete_run();
  end
endmodule : tb
